// [fuse_prog_pkg.sv]
// Package of constants and carrier types for the fuse programming controller.
package fuse_prog_pkg;

   // ****************************************************************
   // Register map of the controller's own AXI4-Lite registers.
   // ****************************************************************
   localparam logic [7:0] ctrl_offset = 8'h00;     // Command register.
   localparam logic [7:0] seq_offset = 8'h04;      // Sequence arguments.
   localparam logic [7:0] status_offset = 8'h08;   // Busy and power state.
   localparam logic [7:0] readback_offset = 8'h0c; // Fuse bits seen in read mode.
   localparam logic [7:0] timing_offset = 8'h10;   // Pulse width in cycles.

   // Field positions in the command register.
   localparam int cmd_lsb = 0;  // Command code, bits 2..0.
   localparam int go_bit = 3;   // Writing one starts the command.
   // Field positions in the sequence register.
   localparam int mode_lsb = 0;   // Mode key, bits 1..0.
   localparam int param_lsb = 4;  // Parameter key, bits 6..4.
   localparam int code_lsb = 8;   // Code or bit count, bits 15..8.

   // ****************************************************************
   // Timing figures.
   // ****************************************************************
   localparam int clk_mhz = 20;              // Core clock rate.
   localparam int pulse_us = 20;             // Default programming pulse width.
   localparam int pulse_cycles = pulse_us * clk_mhz;
   localparam int gap_us = 20;               // Low time between pulses.
   localparam int gap_cycles = gap_us * clk_mhz;
   localparam int blow_us = 100;             // Blow pulse width.
   localparam int blow_cycles = blow_us * clk_mhz;
   localparam int power_off_us = 200;        // Supply off time of a power cycle.
   localparam int power_off_cycles = power_off_us * clk_mhz;

   // ****************************************************************
   // Commands, levels and carriers.
   // ****************************************************************
   localparam logic [2:0] cmd_power_cycle = 3'h1; // Cycle the device supply.
   localparam logic [2:0] cmd_try = 3'h2;         // Select parameter and add code pulses.
   localparam logic [2:0] cmd_blow = 3'h3;        // Address one bit and blow it.
   localparam logic [2:0] cmd_read = 3'h4;        // Read nine fuse bits.
   localparam logic [2:0] cmd_try_next = 3'h5;    // Re-enter parameter selection in try mode.
   localparam int read_bits = 9;                  // Bits 0 to 8 are reported.

   // Pin level requested from the analog driver.
   typedef enum logic [1:0] {
      level_low = 2'h0,
      level_mid = 2'h1,
      level_high = 2'h2
   } level_type;

   // Drive request toward the pin driver.
   typedef struct packed {
      logic drive_en;      // The programmer drives the output pin.
      level_type level;    // Level to drive.
      logic supply_on;     // Device supply switched on.
   } pin_drive_type;

endpackage : fuse_prog_pkg

// [fuse_programmer.sv]
// Host controller that programs the fuse device through its output pin.
//
// The register addresses and the AXI4-Lite register port were chosen for this implementation.
`timescale 1ns/100ps

// Notes on behaviour
// - Cycle supply after each blown bit.
// - Two high pulses enter parameter selection.
// - High blow pulse blows bit, then power cycle.
// - Program offset parameter last in try mode.
module fuse_programmer #(
   parameter int pulse_cycles = fuse_prog_pkg::pulse_cycles,
   parameter int gap_cycles = fuse_prog_pkg::gap_cycles,
   parameter int blow_cycles = fuse_prog_pkg::blow_cycles,
   parameter int power_off_cycles = fuse_prog_pkg::power_off_cycles
) (
   input wire logic core_clk,
   input wire logic reset,
   input wire logic clk_en,
   // AXI4-Lite slave.
   input wire logic [7:0] s_awaddr,
   input wire logic s_awvalid,
   output logic s_awready,
   input wire logic [31:0] s_wdata,
   input wire logic [3:0] s_wstrb,
   input wire logic s_wvalid,
   output logic s_wready,
   output logic [1:0] s_bresp,
   output logic s_bvalid,
   input wire logic s_bready,
   input wire logic [7:0] s_araddr,
   input wire logic s_arvalid,
   output logic s_arready,
   output logic [31:0] s_rdata,
   output logic [1:0] s_rresp,
   output logic s_rvalid,
   input wire logic s_rready,
   // Device side.
   output fuse_prog_pkg::pin_drive_type pin_drive,
   input wire logic current_high   // Comparator: supply current raised by 500 uA.
);

   // ****************************************************************
   // Sequencer states.
   // ****************************************************************
   typedef enum logic [3:0] {
      st_idle = 4'h0,
      st_pulse = 4'h1,
      st_gap = 4'h3,
      st_next = 4'h2,
      st_power_off = 4'h6,
      st_power_on = 4'h7
   } seq_state_type;

   // Pulse step kinds held in the step program.
   localparam logic [1:0] step_high = 2'h0;
   localparam logic [1:0] step_mid = 2'h1;
   localparam logic [1:0] step_blow = 2'h2;
   localparam logic [1:0] step_end = 2'h3;

   seq_state_type state_q, state_d;           // Sequencer state.
   logic [2:0] cmd_q;                         // Running command.
   logic [1:0] mode_q;                        // Mode key argument.
   logic [2:0] param_q;                       // Parameter key argument.
   logic [7:0] code_q;                        // Code or bit count argument.
   logic [15:0] width_q;                      // Programmed pulse width.
   logic [4:0] phase_q;                       // Step phase within a command.
   logic [7:0] count_q;                       // Mids left in the current phase.
   logic [19:0] timer_q;                      // Cycle timer.
   logic [8:0] readback_q;                    // Fuse bits read back.
   logic [3:0] bit_q;                         // Read bit index.
   logic supply_q;                            // Supply switch.
   logic cur_s1_q, cur_s2_q;                  // Synchroniser for the comparator.
   logic aw_q, w_q;                           // Write address and data taken.
   logic [7:0] awaddr_q;                      // Held write address.
   logic [31:0] wdata_q;                      // Held write data.
   logic [1:0] strb_q;                        // Held strobes of the two low byte lanes.

   // ****************************************************************
   // Step program: the pulse train of each command as phases.
   // ****************************************************************
   // Each phase gives the kind of pulse that opens the next phase and its own count of mids.
   logic [1:0] step_kind;   // Kind of current phase.
   logic [7:0] step_mids;   // Mids to send after the phase high.
   always_comb
   begin
      step_kind = step_end;
      step_mids = 8'h00;
      case (phase_q)
         // One high leaves the initial state; mids before it are ignored.
         5'h0:
         begin
            step_kind = step_high;
            step_mids = {6'h00, mode_q};   // Mode key count.
         end
         // Two highs enter parameter selection.
         5'h1:
         begin
            step_kind = step_high;
            step_mids = 8'h00;
         end
         5'h2:
         begin
            step_kind = step_high;
            step_mids = {5'h00, param_q};   // Parameter key count.
         end
         // One high enters bit field addressing and mids address it.
         5'h3:
         begin
            step_kind = (cmd_q == fuse_prog_pkg::cmd_blow) ? step_blow : step_end;
            step_mids = (cmd_q == fuse_prog_pkg::cmd_read) ? 8'(fuse_prog_pkg::read_bits - 1)
                                                           : code_q;
         end
         // The long blow high closes the train; the supply is cycled after it.
         5'h4:
         begin
            step_kind = step_end;
            step_mids = 8'h00;
         end
         default:
         begin
            step_kind = step_end;
            step_mids = 8'h00;
         end
      endcase
   end

   // ****************************************************************
   // Register bus decode.
   // ****************************************************************
   wire busy = (state_q != st_idle);
   wire wr_fire = aw_q && w_q && !s_bvalid;
   wire wr_ctrl = wr_fire && (awaddr_q == fuse_prog_pkg::ctrl_offset);
   wire start = wr_ctrl && wdata_q[fuse_prog_pkg::go_bit] && !busy;
   wire [2:0] new_cmd = wdata_q[fuse_prog_pkg::cmd_lsb +: 3];
   wire timer_done = (timer_q == 20'h00000);
   wire [31:0] status_word = {30'h0, supply_q, busy};
   wire [31:0] rd_word =
      (s_araddr == fuse_prog_pkg::seq_offset) ? {16'h0, code_q, 1'b0, param_q, 2'h0, mode_q} :
      (s_araddr == fuse_prog_pkg::status_offset) ? status_word :
      (s_araddr == fuse_prog_pkg::readback_offset) ? {23'h0, readback_q} :
      (s_araddr == fuse_prog_pkg::timing_offset) ? {16'h0, width_q} :
      (s_araddr == fuse_prog_pkg::ctrl_offset) ? {29'h0, cmd_q} : 32'h0;
   wire rd_known = (s_araddr <= fuse_prog_pkg::timing_offset) && (s_araddr[1:0] == 2'h0);
   assign s_awready = !aw_q;
   assign s_wready = !w_q;
   assign s_arready = !s_rvalid;

   // Write channel: take address and data in either order, answer once both are held.
   always_ff @(posedge core_clk)
   begin
      if (reset)
      begin
         aw_q <= 1'b0;
         w_q <= 1'b0;
         awaddr_q <= 8'h00;
         wdata_q <= 32'h0;
         strb_q <= 2'h0;
         s_bvalid <= 1'b0;
         s_bresp <= 2'h0;
      end
      else if (clk_en)
      begin
         if (s_awvalid && !aw_q)
         begin
            aw_q <= 1'b1;
            awaddr_q <= s_awaddr;
         end
         if (s_wvalid && !w_q)
         begin
            w_q <= 1'b1;
            wdata_q <= s_wdata;
            strb_q <= s_wstrb[1:0];
         end
         if (wr_fire)
         begin
            s_bvalid <= 1'b1;
            s_bresp <= (awaddr_q <= fuse_prog_pkg::timing_offset) ? 2'h0 : 2'h2;
         end
         else if (s_bvalid && s_bready)
         begin
            s_bvalid <= 1'b0;
            aw_q <= 1'b0;
            w_q <= 1'b0;
         end
      end
   end

   // Read channel: one-cycle answer, unmapped addresses give SLVERR.
   always_ff @(posedge core_clk)
   begin
      if (reset)
      begin
         s_rvalid <= 1'b0;
         s_rdata <= 32'h0;
         s_rresp <= 2'h0;
      end
      else if (clk_en)
      begin
         if (s_arvalid && !s_rvalid)
         begin
            s_rvalid <= 1'b1;
            s_rdata <= rd_word;
            s_rresp <= rd_known ? 2'h0 : 2'h2;
         end
         else if (s_rready)
         begin
            s_rvalid <= 1'b0;
         end
      end
   end

   // Argument registers; writes are ignored while a command runs.
   always_ff @(posedge core_clk)
   begin
      if (reset)
      begin
         mode_q <= 2'h2;
         param_q <= 3'h1;
         code_q <= 8'h00;
         width_q <= 16'(pulse_cycles);
         cmd_q <= 3'h0;
      end
      else if (clk_en && wr_fire && !busy)
      begin
         if (awaddr_q == fuse_prog_pkg::seq_offset && strb_q[0])
         begin
            mode_q <= wdata_q[fuse_prog_pkg::mode_lsb +: 2];
            param_q <= wdata_q[fuse_prog_pkg::param_lsb +: 3];
         end
         if (awaddr_q == fuse_prog_pkg::seq_offset && strb_q[1])
         begin
            code_q <= wdata_q[fuse_prog_pkg::code_lsb +: 8];
         end
         if (awaddr_q == fuse_prog_pkg::timing_offset)
         begin
            width_q <= wdata_q[15:0];
         end
         if (start)
         begin
            cmd_q <= new_cmd;
         end
      end
   end

   // ****************************************************************
   // Pulse sequencer.
   // ****************************************************************
   // Next state: pulses and gaps alternate until the step program ends.
   always_comb
   begin
      state_d = state_q;
      case (state_q)
         st_idle:
            if (start)
               state_d = (new_cmd == fuse_prog_pkg::cmd_power_cycle) ? st_power_off : st_pulse;
         st_pulse:
            if (timer_done)
               state_d = st_gap;
         st_gap:
            if (timer_done)
               state_d = st_next;
         st_next:
            if (count_q != 8'h00)
               state_d = st_pulse;
            else if (cmd_q == fuse_prog_pkg::cmd_blow && phase_q == 5'h4)
               state_d = st_power_off;   // Cycle supply after each blown bit.
            else if (step_kind == step_end)
               state_d = st_idle;   // Drive released; trial values stay applied.
            else
               state_d = st_pulse;
         st_power_off:
            if (timer_done)
               state_d = st_power_on;
         st_power_on:
            if (timer_done)
               state_d = st_idle;
         default:
            state_d = st_idle;
      endcase
   end

   // Pulse level: a high opens each phase, mids follow it.
   wire in_mids = (count_q != 8'h00) && !(phase_q == 5'h0 && count_q == 8'h00);
   wire fresh_cmd = start && (new_cmd != fuse_prog_pkg::cmd_power_cycle);

   // State, phase, counters and timer.
   always_ff @(posedge core_clk)
   begin
      if (reset)
      begin
         state_q <= st_idle;
         phase_q <= 5'h0;
         count_q <= 8'h00;
         timer_q <= 20'h00000;
         supply_q <= 1'b1;
         pin_drive <= '{drive_en: 1'b0, level: fuse_prog_pkg::level_low, supply_on: 1'b1};
      end
      else if (clk_en)
      begin
         state_q <= state_d;
         if (!timer_done)
            timer_q <= timer_q - 20'h1;
         case (state_q)
            st_idle:
               if (fresh_cmd)
               begin
                  // Try-next starts straight at the high back into parameter select.
                  phase_q <= (new_cmd == fuse_prog_pkg::cmd_try_next) ? 5'h2 : 5'h0;
                  count_q <= 8'h00;
                  timer_q <= 20'(width_q);
                  pin_drive <= '{drive_en: 1'b1, level: fuse_prog_pkg::level_high, supply_on: 1'b1};
               end
               else if (start)
               begin
                  timer_q <= 20'(power_off_cycles);
               end
            st_pulse:
               if (timer_done)
               begin
                  // Falling edge: the device steps its count here.
                  timer_q <= 20'(gap_cycles);
                  pin_drive.level <= fuse_prog_pkg::level_low;
               end
            st_gap:
               if (timer_done && !in_mids && count_q == 8'h00)
               begin
                  count_q <= step_mids;
               end
               else if (timer_done)
               begin
                  count_q <= count_q - 8'h1;
               end
            st_next:
               if (count_q != 8'h00)
               begin
                  timer_q <= 20'(width_q);
                  pin_drive.level <= fuse_prog_pkg::level_mid;
               end
               else if (state_d == st_pulse)
               begin
                  phase_q <= phase_q + 5'h1;
                  timer_q <= (step_kind == step_blow) ? 20'(blow_cycles) : 20'(width_q);
                  pin_drive.level <= fuse_prog_pkg::level_high;
               end
               else
               begin
                  timer_q <= 20'(power_off_cycles);
                  pin_drive.drive_en <= 1'b0;
               end
            st_power_off:
               if (timer_done)
                  timer_q <= 20'(power_off_cycles);
            default:
               ;
         endcase
         // Power cycle clears the trial state in the device, never blown bits.
         supply_q <= (state_d != st_power_off);
         pin_drive.supply_on <= (state_d != st_power_off);
      end
   end

   // ****************************************************************
   // Read back of the serial fuse report.
   // ****************************************************************
   // Comparator sample is taken at the end of each gap in the addressing phase.
   always_ff @(posedge core_clk)
   begin
      if (reset)
      begin
         cur_s1_q <= 1'b0;
         cur_s2_q <= 1'b0;
         readback_q <= 9'h000;
         bit_q <= 4'h0;
      end
      else if (clk_en)
      begin
         cur_s1_q <= current_high;
         cur_s2_q <= cur_s1_q;
         if (fresh_cmd)
         begin
            bit_q <= 4'h0;
            if (new_cmd == fuse_prog_pkg::cmd_read)
               readback_q <= 9'h000;
         end
         else if (cmd_q == fuse_prog_pkg::cmd_read && state_q == st_gap && timer_done &&
                  phase_q >= 5'h3 && bit_q < 4'(fuse_prog_pkg::read_bits))
         begin
            readback_q[bit_q] <= cur_s2_q;   // Bit 0 first, up to bit 8.
            bit_q <= bit_q + 4'h1;
         end
      end
   end

   // Width of the gain field limits try codes; software keeps the offset last.

endmodule : fuse_programmer

// [fuse_device_model.sv]
// Behavioural model of the pulse programmed fuse device behind the output pin.
`timescale 1ns/100ps
module fuse_device_model (
   input wire logic core_clk,
   input wire fuse_prog_pkg::pin_drive_type pin_drive,
   output logic current_high
);
   fuse_prog_pkg::level_type lvl_q; // Level of the pulse seen at the last edge.
   fuse_prog_pkg::level_type cur; // Level on the pin now; low while released.
   logic [8:0] fuse_q [0:7]; // Blown bits per parameter key.
   logic [6:0] trial_q [0:7]; // Volatile trial codes per parameter key.
   logic final_q; // Final memory fuse.
   logic [2:0] mkey, pkey; // Mode key and parameter key.
   int st, idx; // State 0 init, 1-2 mode, 3 parameter, 4 addressing, 5 blown.
   // Blown fuses start intact and only power-up clears the logic.
   initial
   begin
      for (int i = 0; i < 8; i++) fuse_q[i] = 9'h0;
      for (int i = 0; i < 8; i++) trial_q[i] = 7'h0;
      final_q = 1'b0;
      st = 0;
      idx = 0;
      mkey = 3'h0;
      pkey = 3'h0;
      lvl_q = fuse_prog_pkg::level_low;
   end
   // A completed high pulse moves the state machine on.
   task automatic high_event;
      if (st == 4 && mkey == 3'h1 && !final_q && fuse_q[4][8])
         final_q = 1'b1;
      else if (st == 4 && mkey == 3'h1 && !final_q)
         fuse_q[pkey][idx] = 1'b1;
      case (st)
         0, 1, 2: st = st + 1;
         3: st = 4;
         default: st = (mkey == 3'h2) ? 3 : (mkey == 3'h1) ? 5 : st;
      endcase
      if (st == 3)
         pkey = 3'h0;
      idx = 0;
   endtask : high_event
   // A completed mid pulse counts a key, a code or a bit position.
   task automatic mid_event;
      if (st == 1)
         mkey = mkey + 3'h1;
      else if (st == 3)
         pkey = pkey + 3'h1;
      else if (st == 4 && mkey == 3'h2 && trial_q[pkey] != 7'h7f)
         trial_q[pkey] = trial_q[pkey] + 7'h1;
      else if (st == 4)
         idx++;
   endtask : mid_event
   // Pulses are classified at their falling edge; trial codes survive release.
   always @(posedge core_clk)
   begin
      cur = pin_drive.drive_en ? pin_drive.level : fuse_prog_pkg::level_low;
      if (!pin_drive.supply_on)
      begin
         st = 0;
         idx = 0;
         mkey = 3'h0;
         pkey = 3'h0;
         for (int i = 0; i < 8; i++) trial_q[i] = 7'h0;
      end
      else if (lvl_q == fuse_prog_pkg::level_high && cur == fuse_prog_pkg::level_low)
         high_event();
      else if (lvl_q == fuse_prog_pkg::level_mid && cur == fuse_prog_pkg::level_low)
         mid_event();
      lvl_q = cur;
      // Read mode shows each fuse as raised current, locked or not.
      current_high <= st == 4 && mkey == 3'h3 && idx < 9 && fuse_q[pkey][idx];
   end
endmodule : fuse_device_model

// [fuse_programmer_sva.sv]
// Checker of the fuse programmer's bus answers and pin drive.
`timescale 1ns/100ps
module fuse_programmer_sva (
   input wire logic core_clk,
   input wire logic reset,
   input wire logic s_awvalid,
   input wire logic s_awready,
   input wire logic s_wvalid,
   input wire logic s_wready,
   input wire logic [1:0] s_bresp,
   input wire logic s_bvalid,
   input wire logic s_bready,
   input wire logic [7:0] s_araddr,
   input wire logic s_arvalid,
   input wire logic s_arready,
   input wire logic [31:0] s_rdata,
   input wire logic [1:0] s_rresp,
   input wire logic s_rvalid,
   input wire logic s_rready,
   input wire fuse_prog_pkg::pin_drive_type pin_drive
);
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (reset);
   property p_ar_excl; s_rvalid |-> !s_arready; endproperty
   property p_r_next; s_arvalid && s_arready |=> s_rvalid; endproperty
   property p_r_hold; s_rvalid && !s_rready |=> s_rvalid && $stable(s_rdata); endproperty
   property p_b_hold; s_bvalid && !s_bready |=> s_bvalid && $stable(s_bresp); endproperty
   property p_b_next; s_awvalid && s_awready && s_wvalid && s_wready |-> ##2 s_bvalid; endproperty
   property p_b_once; s_bvalid && s_bready |=> !s_bvalid; endproperty
   property p_unmapped;
      s_arvalid && s_arready && s_araddr > 8'h10 |=> s_rresp == 2'h2 && s_rdata == 32'h0;
   endproperty
   property p_rst_drive;
      $fell(reset) |-> !pin_drive.drive_en && pin_drive.supply_on
         && pin_drive.level == fuse_prog_pkg::level_low;
   endproperty
   property p_level; pin_drive.level != 2'h3; endproperty
   a_ar_excl: assert property (p_ar_excl) else $error("read taken while answer pending");
   a_r_next: assert property (p_r_next) else $error("read answer late");
   a_r_hold: assert property (p_r_hold) else $error("read answer dropped");
   a_b_hold: assert property (p_b_hold) else $error("write answer dropped");
   a_b_next: assert property (p_b_next) else $error("write answer late");
   a_b_once: assert property (p_b_once) else $error("write answered twice");
   a_unmapped: assert property (p_unmapped) else $error("unmapped read not refused");
   a_rst_drive: assert property (p_rst_drive) else $error("pin driven after reset");
   a_level: assert property (p_level) else $error("illegal pin level");
   c_refused: cover property (s_rvalid && s_rresp == 2'h2);
   c_high: cover property (pin_drive.level == fuse_prog_pkg::level_high);
   c_power: cover property (!pin_drive.supply_on);
endmodule : fuse_programmer_sva
bind fuse_programmer fuse_programmer_sva fuse_programmer_sva_i (.core_clk, .reset, .s_awvalid,
   .s_awready, .s_wvalid, .s_wready, .s_bresp, .s_bvalid, .s_bready, .s_araddr, .s_arvalid,
   .s_arready, .s_rdata, .s_rresp, .s_rvalid, .s_rready, .pin_drive);

// [test_fuse_programmer.sv]
// Self-checking testbench of the fuse programmer against a device model.
`timescale 1ns/100ps
module test_fuse_programmer;
   logic core_clk, reset, clk_en, current_high;
   logic [7:0] s_awaddr, s_araddr;
   logic [31:0] s_wdata, s_rdata, rd;
   logic [3:0] s_wstrb;
   logic s_awvalid, s_awready, s_wvalid, s_wready, s_bvalid, s_bready;
   logic s_arvalid, s_arready, s_rvalid, s_rready;
   logic [1:0] s_bresp, s_rresp;
   logic [34:0] expect_q[$]; // Bit 34 marks a read whose answer is compared.
   logic [34:0] got;
   logic [8:0] bit_mask;
   fuse_prog_pkg::pin_drive_type pin_drive;
   int fail_count, n_checks, seed, n;
   fuse_programmer #(.pulse_cycles(4), .gap_cycles(4), .blow_cycles(4), .power_off_cycles(4))
      fuse_programmer_i (.core_clk, .reset, .clk_en, .s_awaddr, .s_awvalid, .s_awready, .s_wdata,
      .s_wstrb, .s_wvalid, .s_wready, .s_bresp, .s_bvalid, .s_bready, .s_araddr, .s_arvalid,
      .s_arready, .s_rdata, .s_rresp, .s_rvalid, .s_rready, .pin_drive, .current_high);
   fuse_device_model fuse_device_model_i (.core_clk, .pin_drive, .current_high);
   initial
   begin
      core_clk = 1'b0;
      forever #25 core_clk = ~core_clk;
   end
   task automatic check(input logic [34:0] seen, input logic [34:0] exp);
      n_checks++;
      if (seen !== exp)
      begin
         fail_count++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : check
   task automatic final_report;
      $display("checks %0d mismatches %0d", n_checks, fail_count);
      if (fail_count == 0 && n_checks > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask : final_report
   task automatic axi_write(input logic [7:0] a, input logic [31:0] d);
      @(posedge core_clk);
      s_awaddr <= a;
      s_wdata <= d;
      s_awvalid <= 1'b1;
      s_wvalid <= 1'b1;
      s_bready <= 1'b1;
      do
      begin
         @(posedge core_clk);
         if (s_awvalid && s_awready) s_awvalid <= 1'b0;
         if (s_wvalid && s_wready) s_wvalid <= 1'b0;
      end
      while (!s_bvalid);
      check(35'(s_bresp), (a > fuse_prog_pkg::timing_offset) ? 35'h2 : 35'h0);
      s_bready <= 1'b0;
   endtask : axi_write
   task automatic axi_read(input logic [7:0] a, input logic chk, input logic [33:0] exp);
      @(posedge core_clk);
      s_araddr <= a;
      s_arvalid <= 1'b1;
      s_rready <= 1'b1;
      expect_q.push_back({chk, exp});
      do
      begin
         @(posedge core_clk);
         if (s_arvalid && s_arready) s_arvalid <= 1'b0;
      end
      while (!s_rvalid);
      rd = s_rdata;
      s_rready <= 1'b0;
   endtask : axi_read
   // Writes arguments, starts a command and polls busy until it clears.
   task automatic run(input logic [2:0] cmd, input logic [31:0] args);
      int k;
      k = 0;
      axi_write(fuse_prog_pkg::seq_offset, args);
      axi_write(fuse_prog_pkg::ctrl_offset, {28'h0, 1'b1, cmd});
      rd = 32'h1;
      while (rd[0] !== 1'b0 && k < 3000)
      begin
         axi_read(fuse_prog_pkg::status_offset, 1'b0, 34'h0);
         k++;
      end
      if (k == 3000) fail_count++;
   endtask : run
   // Compares each marked read answer with the oldest noted expectation.
   always @(posedge core_clk)
   begin
      if (s_rvalid && s_rready && expect_q.size() > 0)
      begin
         got = expect_q.pop_front();
         if (got[34]) check({1'b0, s_rresp, s_rdata}, {1'b0, got[33:0]});
      end
   end
   initial
   begin
      #(50 * 80000);
      fail_count++;
      final_report();
   end
   initial
   begin
      {s_awaddr, s_araddr, s_wdata, s_awvalid, s_wvalid, s_bready, s_arvalid, s_rready} = '0;
      s_wstrb = 4'hf;
      clk_en = 1'b1;
      reset = 1'b1;
      seed = 35339;
      repeat (4) @(posedge core_clk);
      reset <= 1'b0;
      axi_read(fuse_prog_pkg::seq_offset, 1'b1, 34'h12);
      axi_read(fuse_prog_pkg::status_offset, 1'b1, 34'h2);
      axi_read(8'h14, 1'b1, {2'h2, 32'h0});
      axi_write(fuse_prog_pkg::timing_offset, 32'h6);
      axi_read(fuse_prog_pkg::timing_offset, 1'b1, 34'h6);
      axi_write(8'h14, 32'h0);
      // A power cycle frozen by the clock enable keeps the supply off.
      axi_write(fuse_prog_pkg::ctrl_offset, 32'h9);
      clk_en <= 1'b0;
      repeat (20) @(posedge core_clk);
      check(35'(pin_drive.supply_on), 35'h0);
      clk_en <= 1'b1;
      run(fuse_prog_pkg::cmd_power_cycle, 32'h0);
      $display("test registers done");
      n = ($random(seed) & 32'h7fffffff) % 9;
      bit_mask = 9'h1 << n;
      run(fuse_prog_pkg::cmd_blow, {16'h0, n[7:0], 8'h11});
      run(fuse_prog_pkg::cmd_power_cycle, 32'h0);
      check(35'(fuse_device_model_i.fuse_q[1]), 35'(bit_mask));
      run(fuse_prog_pkg::cmd_read, 32'h13);
      axi_read(fuse_prog_pkg::readback_offset, 1'b1, 34'(bit_mask));
      run(fuse_prog_pkg::cmd_power_cycle, 32'h0);
      run(fuse_prog_pkg::cmd_read, 32'h13);
      axi_read(fuse_prog_pkg::readback_offset, 1'b1, 34'(bit_mask));
      $display("test blow and read done");
      run(fuse_prog_pkg::cmd_power_cycle, 32'h0);
      run(fuse_prog_pkg::cmd_try, 32'hc812);
      run(fuse_prog_pkg::cmd_try_next, 32'h0522);
      check(35'(fuse_device_model_i.trial_q[1]), 35'h7f);
      check(35'(fuse_device_model_i.trial_q[2]), 35'h5);
      $display("test try done");
      run(fuse_prog_pkg::cmd_power_cycle, 32'h0);
      run(fuse_prog_pkg::cmd_blow, 32'h0841);
      run(fuse_prog_pkg::cmd_power_cycle, 32'h0);
      run(fuse_prog_pkg::cmd_blow, 32'h0011);
      check(35'(fuse_device_model_i.final_q), 35'h1);
      check(35'(fuse_device_model_i.fuse_q[1]), 35'(bit_mask));
      run(fuse_prog_pkg::cmd_power_cycle, 32'h0);
      run(fuse_prog_pkg::cmd_read, 32'h43);
      axi_read(fuse_prog_pkg::readback_offset, 1'b1, 34'h100);
      $display("test lock done");
      final_report();
   end
endmodule : test_fuse_programmer
